// ==== rtl/cfs_pkg.sv ====
// Package with register map, field positions and encodings of the status bank.
package cfs_pkg;

	// -----------------------------------------------------------------
	// Register offsets
	// -----------------------------------------------------------------
	localparam logic [7:0] CFS_OFF_IRQ_CRC_TIMER_FIFO_STATUS = 8'hDF;
	localparam logic [7:0] CFS_OFF_MODEM_AND_LINK_STATUS     = 8'hE9;
	localparam logic [7:0] CFS_OFF_EVENT_STATUS              = 8'hF0;
	localparam logic [7:0] CFS_OFF_EVENT_MASK                = 8'hF1;
	localparam logic [7:0] CFS_OFF_FIFO_THRESHOLD            = 8'hF2;

	// -----------------------------------------------------------------
	// Field positions, first status register
	// -----------------------------------------------------------------
	localparam int CFS_S1_IRQ1_BIT   = 7;
	localparam int CFS_S1_CRCZ_BIT   = 6;
	localparam int CFS_S1_CRCD_BIT   = 5;
	localparam int CFS_S1_IRQ0_BIT   = 4;
	localparam int CFS_S1_TACT_BIT   = 3;
	localparam int CFS_S1_FIELD_BIT  = 2;
	localparam int CFS_S1_HIWM_BIT   = 1;
	localparam int CFS_S1_LOWM_BIT   = 0;

	// -----------------------------------------------------------------
	// Field positions, second status register
	// -----------------------------------------------------------------
	localparam int CFS_S2_OVCLR_BIT  = 7;
	localparam int CFS_S2_RSVD_BIT   = 6;
	localparam int CFS_S2_FREQ_BIT   = 5;
	localparam int CFS_S2_TSEL_BIT   = 4;
	localparam int CFS_S2_CIPH_BIT   = 3;
	localparam int CFS_S2_PHASE_MSB  = 2;

	// -----------------------------------------------------------------
	// Reset values and sizes
	// -----------------------------------------------------------------
	localparam logic [7:0] CFS_RST_MODEM_AND_LINK_STATUS = 8'h00;
	localparam logic [7:0] CFS_RST_EVENT_MASK            = 8'h00;
	localparam logic [5:0] CFS_RST_FIFO_THRESHOLD        = 6'h08;
	localparam int         CFS_FIFO_DEPTH                = 64;
	localparam int         CFS_NUM_EVENTS                = 4;

	// -----------------------------------------------------------------
	// Modem phase encodings
	// -----------------------------------------------------------------
	localparam logic [2:0] CFS_PH_IDLE      = 3'h0;
	localparam logic [2:0] CFS_PH_WAIT_SEND = 3'h1;
	localparam logic [2:0] CFS_PH_TX_WAIT   = 3'h2;
	localparam logic [2:0] CFS_PH_TX        = 3'h3;
	localparam logic [2:0] CFS_PH_RX_WAIT   = 3'h4;
	localparam logic [2:0] CFS_PH_WAIT_DATA = 3'h5;
	localparam logic [2:0] CFS_PH_RX        = 3'h6;

endpackage : cfs_pkg

// ==== rtl/cfs_sync.sv ====
// Two flip-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/1ps
module cfs_sync
	import cfs_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             ref_clk_i,
	input  wire logic             rstn_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule : cfs_sync

// ==== rtl/cfs_watermark.sv ====
// FIFO high and low watermark comparators.
`timescale 1ns/1ps
module cfs_watermark
	import cfs_pkg::*;
#(
	parameter int DEPTH = CFS_FIFO_DEPTH
)
(
	input  wire logic [6:0] fifo_byte_count_i,
	input  wire logic [5:0] fifo_threshold_i,
	output logic            fifo_high_watermark_o,
	output logic            fifo_low_watermark_o
);

	logic [7:0] free_space;

	always_comb
	begin
		free_space = 8'(DEPTH) - {1'b0, fifo_byte_count_i};
		fifo_high_watermark_o = free_space <= {2'b00, fifo_threshold_i};
		fifo_low_watermark_o  = fifo_byte_count_i <= {1'b0, fifo_threshold_i};
	end

endmodule : cfs_watermark

// ==== rtl/cfs_status_regs.sv ====
// Status register bank of the contactless front-end.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module cfs_status_regs
	import cfs_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       rstn_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_write_i,
	input  wire logic       reg_read_i,
	output logic      [7:0] reg_rdata_o,
	input  wire logic       irq_group_one_pending_i,
	input  wire logic       irq_group_zero_pending_i,
	input  wire logic       checksum_busy_i,
	input  wire logic       checksum_finish_i,
	input  wire logic       checksum_result_zero_i,
	input  wire logic       checksum_calculate_cmd_i,
	input  wire logic       timer_enabled_i,
	input  wire logic       field_present_i,
	input  wire logic       carrier_frequency_good_i,
	input  wire logic [6:0] fifo_byte_count_i,
	input  wire logic       select_received_i,
	input  wire logic       poll_answered_i,
	input  wire logic       card_authenticate_ok_i,
	input  wire logic [2:0] modem_phase_i,
	input  wire logic       overheat_alarm_i,
	output logic            overheat_error_o,
	output logic            irq_o
);

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [1:0] pins_sync;

	cfs_sync #(
		.WIDTH (2)
	) u_sync (
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.async_i   ({field_present_i, carrier_frequency_good_i}),
		.sync_o    (pins_sync)
	);

	logic field_s;
	logic freq_s;
	assign field_s = pins_sync[1];
	assign freq_s  = pins_sync[0];

	// ---------------------------------------------------------------
	// Watermarks
	// ---------------------------------------------------------------
	logic [5:0] thr_q;
	logic [5:0] thr_d;
	logic       hi_wm;
	logic       lo_wm;

	cfs_watermark #(
		.DEPTH (CFS_FIFO_DEPTH)
	) u_wm (
		.fifo_byte_count_i     (fifo_byte_count_i),
		.fifo_threshold_i      (thr_q),
		.fifo_high_watermark_o (hi_wm),
		.fifo_low_watermark_o  (lo_wm)
	);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic       crc_zero_q;
	logic       crc_zero_d;
	logic       crc_done_q;
	logic       crc_done_d;
	logic       tsel_q;
	logic       tsel_d;
	logic       ciph_q;
	logic       ciph_d;
	logic       ovclr_q;
	logic       ovclr_d;
	logic       overheat_q;
	logic       overheat_d;
	logic [3:0] evt_q;
	logic [3:0] evt_d;
	logic [3:0] mask_q;
	logic [3:0] mask_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic [7:0] status1;
	logic [7:0] status2;
	logic [3:0] evt_in;
	logic       wr_s2;

	assign wr_s2 = reg_write_i && reg_addr_i == CFS_OFF_MODEM_AND_LINK_STATUS;

	always_comb
	begin
		status1 = 8'h00;
		status1[CFS_S1_IRQ1_BIT]  = irq_group_one_pending_i;
		status1[CFS_S1_CRCZ_BIT]  = crc_zero_q;
		status1[CFS_S1_CRCD_BIT]  = crc_done_q;
		status1[CFS_S1_IRQ0_BIT]  = irq_group_zero_pending_i;
		status1[CFS_S1_TACT_BIT]  = timer_enabled_i;
		status1[CFS_S1_FIELD_BIT] = field_s;
		status1[CFS_S1_HIWM_BIT]  = hi_wm;
		status1[CFS_S1_LOWM_BIT]  = lo_wm;
		status2 = 8'h00;
		status2[CFS_S2_OVCLR_BIT] = ovclr_q;
		status2[CFS_S2_FREQ_BIT]  = freq_s;
		status2[CFS_S2_TSEL_BIT]  = tsel_q;
		status2[CFS_S2_CIPH_BIT]  = ciph_q;
		status2[CFS_S2_PHASE_MSB:0] = modem_phase_i;
	end

	always_comb
	begin
		crc_zero_d = crc_zero_q;
		if (checksum_busy_i)
			crc_zero_d = 1'b0;
		else if (checksum_finish_i)
			crc_zero_d = checksum_result_zero_i;
		crc_done_d = crc_done_q;
		if (checksum_finish_i)
			crc_done_d = 1'b1;
		else if (checksum_calculate_cmd_i)
			crc_done_d = 1'b0;
		tsel_d = tsel_q;
		if (!field_s)
			tsel_d = 1'b0;
		else if (select_received_i || poll_answered_i)
			tsel_d = 1'b1;
		ciph_d = ciph_q;
		if (card_authenticate_ok_i)
			ciph_d = 1'b1;
		else if (wr_s2 && !reg_wdata_i[CFS_S2_CIPH_BIT])
			ciph_d = 1'b0;
		ovclr_d = wr_s2 ? reg_wdata_i[CFS_S2_OVCLR_BIT] : ovclr_q;
		overheat_d = overheat_q;
		if (overheat_alarm_i)
			overheat_d = 1'b1;
		else if (wr_s2 && reg_wdata_i[CFS_S2_OVCLR_BIT])
			overheat_d = 1'b0;
		thr_d = thr_q;
		if (reg_write_i && reg_addr_i == CFS_OFF_FIFO_THRESHOLD)
			thr_d = reg_wdata_i[5:0];
		mask_d = mask_q;
		if (reg_write_i && reg_addr_i == CFS_OFF_EVENT_MASK)
			mask_d = reg_wdata_i[3:0];
		evt_in = {checksum_finish_i, tsel_d & ~tsel_q,
			overheat_d & ~overheat_q, hi_wm};
		evt_d = evt_q;
		if (reg_read_i && reg_addr_i == CFS_OFF_EVENT_STATUS)
			evt_d = 4'h0;
		evt_d = evt_d | evt_in;
		rdata_d = 8'h00;
		if (reg_read_i)
		begin
			case (reg_addr_i)
				CFS_OFF_IRQ_CRC_TIMER_FIFO_STATUS: rdata_d = status1;
				CFS_OFF_MODEM_AND_LINK_STATUS:     rdata_d = status2;
				CFS_OFF_EVENT_STATUS:   rdata_d = {4'h0, evt_q};
				CFS_OFF_EVENT_MASK:     rdata_d = {4'h0, mask_q};
				CFS_OFF_FIFO_THRESHOLD: rdata_d = {2'b00, thr_q};
				default:                rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			crc_zero_q <= 1'b0;
			crc_done_q <= 1'b1;
			tsel_q     <= 1'b0;
			ciph_q     <= 1'b0;
			ovclr_q    <= 1'b0;
			overheat_q <= 1'b0;
			thr_q      <= CFS_RST_FIFO_THRESHOLD;
			mask_q     <= CFS_RST_EVENT_MASK[3:0];
			evt_q      <= 4'h0;
			rdata_q    <= 8'h00;
		end
		else
		begin
			crc_zero_q <= crc_zero_d;
			crc_done_q <= crc_done_d;
			tsel_q     <= tsel_d;
			ciph_q     <= ciph_d;
			ovclr_q    <= ovclr_d;
			overheat_q <= overheat_d;
			thr_q      <= thr_d;
			mask_q     <= mask_d;
			evt_q      <= evt_d;
			rdata_q    <= rdata_d;
		end
	end

	assign reg_rdata_o      = rdata_q;
	assign overheat_error_o = overheat_q;
	assign irq_o            = |(evt_q & mask_q);

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_irq1;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		reg_read_i && reg_addr_i == CFS_OFF_IRQ_CRC_TIMER_FIFO_STATUS
		|=> reg_rdata_o[7] == $past(irq_group_one_pending_i);
	endproperty
	a_irq1: assert property (p_irq1) else $error("irq1 bit wrong");

	property p_irq0;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		reg_read_i && reg_addr_i == CFS_OFF_IRQ_CRC_TIMER_FIFO_STATUS
		|=> reg_rdata_o[4] == $past(irq_group_zero_pending_i);
	endproperty
	a_irq0: assert property (p_irq0) else $error("irq0 bit wrong");

	property p_crc_busy;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		checksum_busy_i |=> !crc_zero_q;
	endproperty
	a_crc_busy: assert property (p_crc_busy) else $error("crc zero busy");

	property p_crc_done;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		checksum_finish_i |=> crc_done_q;
	endproperty
	a_crc_done: assert property (p_crc_done) else $error("crc done");

	property p_tsel_off;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		!field_s |=> !tsel_q;
	endproperty
	a_tsel_off: assert property (p_tsel_off) else $error("tsel kept");

	property p_ciph;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		card_authenticate_ok_i |=> ciph_q;
	endproperty
	a_ciph: assert property (p_ciph) else $error("cipher not set");

	property p_ovclr;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		wr_s2 && reg_wdata_i[7] && !overheat_alarm_i |=> !overheat_error_o;
	endproperty
	a_ovclr: assert property (p_ovclr) else $error("overheat kept");

	property p_s2_rsvd;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		reg_read_i && reg_addr_i == CFS_OFF_MODEM_AND_LINK_STATUS
		|=> !reg_rdata_o[6] && reg_rdata_o[5] == $past(freq_s);
	endproperty
	a_s2_rsvd: assert property (p_s2_rsvd) else $error("status2 bad");

	property p_lowm;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		reg_read_i && reg_addr_i == CFS_OFF_IRQ_CRC_TIMER_FIFO_STATUS
		|=> reg_rdata_o[0] == ($past(fifo_byte_count_i) <= {1'b0, $past(thr_q)});
	endproperty
	a_lowm: assert property (p_lowm) else $error("low watermark");

	property p_crc_zero;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		checksum_finish_i && !checksum_busy_i
		|=> crc_zero_q == $past(checksum_result_zero_i);
	endproperty
	a_crc_zero: assert property (p_crc_zero) else $error("crc zero");

	property p_tact;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		reg_read_i && reg_addr_i == CFS_OFF_IRQ_CRC_TIMER_FIFO_STATUS
		|=> reg_rdata_o[3] == $past(timer_enabled_i);
	endproperty
	a_tact: assert property (p_tact) else $error("timer bit wrong");

	property p_field;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		reg_read_i && reg_addr_i == CFS_OFF_IRQ_CRC_TIMER_FIFO_STATUS
		|=> reg_rdata_o[2] == $past(field_s);
	endproperty
	a_field: assert property (p_field) else $error("field bit");

	property p_hiwm;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		reg_read_i && reg_addr_i == CFS_OFF_IRQ_CRC_TIMER_FIFO_STATUS
		|=> reg_rdata_o[1] ==
			(7'(CFS_FIFO_DEPTH) - $past(fifo_byte_count_i)
			<= {1'b0, $past(thr_q)});
	endproperty
	a_hiwm: assert property (p_hiwm) else $error("high watermark");

	property p_phase;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		reg_read_i && reg_addr_i == CFS_OFF_MODEM_AND_LINK_STATUS
		|=> reg_rdata_o[2:0] == $past(modem_phase_i);
	endproperty
	a_phase: assert property (p_phase) else $error("phase wrong");

	property p_tsel_ro;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		wr_s2 && field_s && !select_received_i && !poll_answered_i
		|=> tsel_q == $past(tsel_q);
	endproperty
	a_tsel_ro: assert property (p_tsel_ro) else $error("tsel wr");

endmodule : cfs_status_regs

// ==== tb/cfs_fw_model.sv ====
// Firmware model that reads and writes the status bank registers.
`timescale 1ns/1ps
module cfs_fw_model
(
	input  wire logic       ref_clk_i,
	input  wire logic [7:0] reg_rdata_i,
	output logic      [7:0] reg_addr_o,
	output logic      [7:0] reg_wdata_o,
	output logic            reg_write_o,
	output logic            reg_read_o
);
	initial
	begin
		reg_addr_o  = 8'h00;
		reg_wdata_o = 8'h00;
		reg_write_o = 1'b0;
		reg_read_o  = 1'b0;
	end

	// One write cycle with address and data beside the strobe.
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		reg_addr_o  <= a;
		reg_wdata_o <= d;
		reg_write_o <= 1'b1;
		@(posedge ref_clk_i);
		reg_write_o <= 1'b0;
	endtask : wr_reg

	// One read cycle; the data stand in the following cycle only.
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		reg_addr_o <= a;
		reg_read_o <= 1'b1;
		@(posedge ref_clk_i);
		reg_read_o <= 1'b0;
		#1;
		d = reg_rdata_i;
	endtask : rd_reg
endmodule : cfs_fw_model

// ==== tb/test_cfs_status_regs.sv ====
// Self-checking testbench of the status register bank.
`timescale 1ns/1ps
module test_cfs_status_regs
	import cfs_pkg::*;
;
	logic       ref_clk_i = 1'b0;
	logic       rstn_i = 1'b0;
	logic       irq1 = 0, irq0 = 0, cbusy = 0, cfin = 0, czero = 0, ccmd = 0;
	logic       ten = 0, fld = 0, frq = 0, sel = 0, poll = 0, auth = 0;
	logic       alarm = 0;
	logic [6:0] cnt = 7'h00;
	logic [2:0] ph = 3'h0;
	wire  [7:0] addr, wdata, rdata;
	wire        wr, rd, ovh, irq;
	logic [5:0] thr = 6'h08;
	logic       crcz = 0, crcd = 1, tsel = 0, ciph = 0, ovc = 0, oerr = 0;
	logic [7:0] ev = 8'h00, mask = 8'h00;
	logic [31:0] r, d;
	int         error_cnt = 0, comparisons = 0;
	int         tc[4] = '{60, 59, 4, 5};

	always #50 ref_clk_i = ~ref_clk_i;

	cfs_fw_model cfs_fw_model_i (.ref_clk_i(ref_clk_i), .reg_rdata_i(rdata),
		.reg_addr_o(addr), .reg_wdata_o(wdata), .reg_write_o(wr),
		.reg_read_o(rd));

	cfs_status_regs cfs_status_regs_i (.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata),
		.irq_group_one_pending_i(irq1), .irq_group_zero_pending_i(irq0),
		.checksum_busy_i(cbusy), .checksum_finish_i(cfin),
		.checksum_result_zero_i(czero), .checksum_calculate_cmd_i(ccmd),
		.timer_enabled_i(ten), .field_present_i(fld),
		.carrier_frequency_good_i(frq), .fifo_byte_count_i(cnt),
		.select_received_i(sel), .poll_answered_i(poll),
		.card_authenticate_ok_i(auth), .modem_phase_i(ph),
		.overheat_alarm_i(alarm), .overheat_error_o(ovh), .irq_o(irq));

	function automatic logic [7:0] s1();
		return {irq1, crcz, crcd, irq0, ten, fld,
			(7'd64 - cnt) <= {1'b0, thr}, cnt <= {1'b0, thr}};
	endfunction : s1

	function automatic logic [7:0] s2();
		return {ovc, 1'b0, frq, tsel, ciph, ph};
	endfunction : s2

	task automatic w(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask : w

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		cfs_fw_model_i.rd_reg(a, v);
		chk(v, exp);
	endtask : rchk

	task automatic test_done();
		if (error_cnt == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial
	begin
		r = $urandom(32'hD7F0C126);
		w(20);
		rstn_i <= 1'b1;
		rchk(CFS_OFF_IRQ_CRC_TIMER_FIFO_STATUS, s1());
		rchk(CFS_OFF_MODEM_AND_LINK_STATUS, 8'h00);
		rchk(CFS_OFF_FIFO_THRESHOLD, 8'h08);
		rchk(CFS_OFF_EVENT_MASK, 8'h00);
		rchk(CFS_OFF_EVENT_STATUS, 8'h00);
		rchk(8'h10, 8'h00);
		for (int i = 0; i < 24; i++)
		begin
			r = $urandom;
			d = $urandom;
			@(posedge ref_clk_i);
			{irq1, irq0, ten, fld, frq} <= r[10:6];
			ph <= 3'(i % 7);
			cnt <= (i < 4) ? 7'(tc[i]) : 7'(r[31:16] % 65);
			thr = (i < 4) ? 6'd4 : r[5:0];
			cfs_fw_model_i.wr_reg(CFS_OFF_FIFO_THRESHOLD, {2'b00, thr});
			cfs_fw_model_i.wr_reg(CFS_OFF_IRQ_CRC_TIMER_FIFO_STATUS, d[7:0]);
			cfs_fw_model_i.wr_reg(CFS_OFF_MODEM_AND_LINK_STATUS, d[15:8]);
			ovc = d[15];
			w(4);
			rchk(CFS_OFF_IRQ_CRC_TIMER_FIFO_STATUS, s1());
			rchk(CFS_OFF_MODEM_AND_LINK_STATUS, s2());
		end
		@(posedge ref_clk_i);
		cnt <= 7'h00;
		w(2);
		rchk(CFS_OFF_EVENT_STATUS, 8'h01);
		for (int k = 1; k >= 0; k--)
		begin
			@(posedge ref_clk_i);
			ccmd <= 1'b1;
			@(posedge ref_clk_i);
			ccmd <= 1'b0;
			cbusy <= 1'b1;
			{crcz, crcd} = 2'b00;
			w(3);
			rchk(CFS_OFF_IRQ_CRC_TIMER_FIFO_STATUS, s1());
			@(posedge ref_clk_i);
			cbusy <= 1'b0;
			cfin <= 1'b1;
			czero <= k[0];
			@(posedge ref_clk_i);
			cfin <= 1'b0;
			{crcz, crcd} = {k[0], 1'b1};
			ev[3] = 1'b1;
			w(2);
			rchk(CFS_OFF_IRQ_CRC_TIMER_FIFO_STATUS, s1());
		end
		mask = 8'h0E;
		cfs_fw_model_i.wr_reg(CFS_OFF_EVENT_MASK, mask);
		rchk(CFS_OFF_EVENT_MASK, mask);
		chk({7'h00, irq}, {7'h00, |(ev & mask)});
		rchk(CFS_OFF_EVENT_STATUS, ev);
		ev = 8'h00;
		w(1);
		chk({7'h00, irq}, 8'h00);
		fld <= 1'b1;
		w(4);
		@(posedge ref_clk_i);
		sel <= 1'b1;
		@(posedge ref_clk_i);
		sel <= 1'b0;
		auth <= 1'b1;
		@(posedge ref_clk_i);
		auth <= 1'b0;
		w(2);
		{tsel, ciph} = 2'b11;
		ev[2] = 1'b1;
		rchk(CFS_OFF_MODEM_AND_LINK_STATUS, s2());
		cfs_fw_model_i.wr_reg(CFS_OFF_MODEM_AND_LINK_STATUS, 8'h00);
		{ovc, ciph} = 2'b00;
		rchk(CFS_OFF_MODEM_AND_LINK_STATUS, s2());
		@(posedge ref_clk_i);
		fld <= 1'b0;
		w(4);
		tsel = 1'b0;
		rchk(CFS_OFF_MODEM_AND_LINK_STATUS, s2());
		rchk(CFS_OFF_IRQ_CRC_TIMER_FIFO_STATUS, s1());
		@(posedge ref_clk_i);
		fld <= 1'b1;
		w(4);
		@(posedge ref_clk_i);
		poll <= 1'b1;
		@(posedge ref_clk_i);
		poll <= 1'b0;
		w(2);
		tsel = 1'b1;
		rchk(CFS_OFF_MODEM_AND_LINK_STATUS, s2());
		@(posedge ref_clk_i);
		alarm <= 1'b1;
		w(3);
		ev[1] = 1'b1;
		chk({7'h00, ovh}, 8'h01);
		cfs_fw_model_i.wr_reg(CFS_OFF_MODEM_AND_LINK_STATUS, 8'h80);
		ovc = 1'b1;
		w(1);
		chk({7'h00, ovh}, 8'h01);
		alarm <= 1'b0;
		w(3);
		chk({7'h00, ovh}, 8'h01);
		cfs_fw_model_i.wr_reg(CFS_OFF_MODEM_AND_LINK_STATUS, 8'h80);
		w(1);
		chk({7'h00, ovh}, 8'h00);
		rchk(CFS_OFF_MODEM_AND_LINK_STATUS, s2());
		chk({7'h00, irq}, {7'h00, |(ev & mask)});
		rchk(CFS_OFF_EVENT_STATUS, ev);
		test_done();
	end
endmodule : test_cfs_status_regs
